// file: verilog/port_ctl_defs.svh
// field positions, widths and reset values of the port control fields
`ifndef PORT_CTL_DEFS_SVH
`define PORT_CTL_DEFS_SVH
`define PTS_LSB 16
`define PTS_MSB 19
`define PLS_LSB 14
`define PLS_MSB 15
`define PHC_BIT 13
`define PPO_BIT 12
`define PTS_RESET 4'h0
`define PLS_RESET 2'h0
`define PHC_RESET 1'b1
`define PPO_RESET 1'b0
`endif

// file: verilog/port_ctl_pkg.sv
// types of the port control block
package port_ctl_pkg;
  typedef enum logic [3:0] {
    TEST_OFF = 4'h0,
    TEST_J = 4'h1,
    TEST_K = 4'h2,
    TEST_SE0_NAK = 4'h3,
    TEST_PACKET = 4'h4,
    TEST_FORCE_ENABLE = 4'h5
  } test_code_type;
  typedef enum logic [1:0] {
    LED_OFF = 2'h0,
    LED_AMBER = 2'h1,
    LED_GREEN = 2'h2,
    LED_UNDEF = 2'h3
  } led_code_type;
endpackage

// file: verilog/port_ctl.sv
// port test, indicator, ownership and power control of one root port
//
// Summary of operation
// RULE1 - test codes 4 packet, 5 force enable, 6 to 15 reserved
// RULE2 - indicator writes ignored without indicator capability
// RULE3 - indicator 00 off, 01 amber, 10 green
// RULE4 - ownership bit resets to one
// RULE5 - configured flag rise clears ownership bit
// RULE6 - configured flag low forces ownership to one
// RULE7 - software hands non high-speed ports to companion
// RULE8 - ownership one means companion owns the port
// RULE9 - no power switching: power bit reads one
// RULE10 - power switching: power bit writable, shows switch
// RULE11 - unpowered port is nonfunctional, reports nothing
// RULE12 - overcurrent on powered port removes power (code removes it only with power switching capability)
// RULE13 - test code zero means normal operation
// RULE14 - undefined codes leave leds off, port normal
`timescale 1ns/1ps
`include "port_ctl_defs.svh"

module port_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic indicator_capability,
  input wire logic power_switch_capability,
  input wire logic configured_flag,
  input wire logic overcurrent_in,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic led_amber,
  output logic led_green,
  output logic port_handover_to_companion,
  output logic hs_owns_port,
  output logic port_power_on,
  output logic port_functional,
  output logic test_active,
  output logic test_j,
  output logic test_k,
  output logic test_se0_nak,
  output logic test_packet,
  output logic test_force_enable
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic [3:0] test_reg;
  logic [3:0] test_next;
  logic [1:0] led_reg;
  logic [1:0] led_next;
  logic owner_reg;
  logic owner_next;
  logic power_reg;
  logic power_next;
  logic cfg_prev_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [6:0] outs_reg;
  logic [6:0] outs_next;
  logic cfg_rise;
  logic power_eff;
  logic oc_trip;
  logic led_code_amber;
  logic led_code_green;
  logic test_known;

  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  function automatic logic code_is(input logic [3:0] code, input port_ctl_pkg::test_code_type t);
    code_is = (code == t);
  endfunction

  assign cfg_rise = configured_flag && !cfg_prev_reg;
  // without switches the port is always powered
  assign power_eff = power_switch_capability ? power_reg : 1'b1; // RULE9 RULE10
  assign oc_trip = power_switch_capability && power_reg && overcurrent_in; // RULE12

  assign test_next = reg_wr ? reg_wdata[`PTS_MSB:`PTS_LSB] : test_reg;
  // writes without indicator capability are dropped
  assign led_next = (reg_wr && indicator_capability) ?
    reg_wdata[`PLS_MSB:`PLS_LSB] : led_reg; // RULE2
  // configured flag low forces, its rise clears, both above software writes
  assign owner_next = !configured_flag ? 1'b1 : // RULE6
    cfg_rise ? 1'b0 : // RULE5
    reg_wr ? reg_wdata[`PHC_BIT] : owner_reg; // RULE7
  // overcurrent wins over a write of one
  assign power_next = oc_trip ? 1'b0 : // RULE12
    (reg_wr && power_switch_capability) ? reg_wdata[`PPO_BIT] : power_reg; // RULE10

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      test_reg <= `PTS_RESET;
      led_reg <= `PLS_RESET;
      owner_reg <= `PHC_RESET; // RULE4
      power_reg <= `PPO_RESET;
      cfg_prev_reg <= 1'b0;
    end else begin
      test_reg <= test_next;
      led_reg <= led_next;
      owner_reg <= owner_next;
      power_reg <= power_next;
      cfg_prev_reg <= configured_flag;
    end
  end

  // decode of indicator codes, gated by indicator capability, and of test codes
  assign led_code_amber = indicator_capability && (led_reg == port_ctl_pkg::LED_AMBER); // RULE3
  assign led_code_green = indicator_capability &&
    (led_reg == port_ctl_pkg::LED_GREEN); // RULE3 RULE14
  assign test_known = (test_reg != port_ctl_pkg::TEST_OFF) && (test_reg <= 4'h5); // RULE13 RULE14

  always_comb begin
    rdata_next = 32'h0000_0000;
    rdata_next[`PTS_MSB:`PTS_LSB] = test_reg;
    rdata_next[`PLS_MSB:`PLS_LSB] = led_reg;
    rdata_next[`PHC_BIT] = owner_reg;
    rdata_next[`PPO_BIT] = power_eff; // RULE9
  end

  always_comb begin
    outs_next = 7'h00;
    if (power_eff) begin // RULE11
      outs_next[0] = test_known;
      outs_next[1] = code_is(test_reg, port_ctl_pkg::TEST_J);
      outs_next[2] = code_is(test_reg, port_ctl_pkg::TEST_K);
      outs_next[3] = code_is(test_reg, port_ctl_pkg::TEST_SE0_NAK);
      outs_next[4] = code_is(test_reg, port_ctl_pkg::TEST_PACKET); // RULE1
      outs_next[5] = code_is(test_reg, port_ctl_pkg::TEST_FORCE_ENABLE); // RULE1
      outs_next[6] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata_reg <= 32'h0000_0000;
      outs_reg <= 7'h00;
    end else begin
      rdata_reg <= rdata_next;
      outs_reg <= outs_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign test_active = outs_reg[0];
  assign test_j = outs_reg[1];
  assign test_k = outs_reg[2];
  assign test_se0_nak = outs_reg[3];
  assign test_packet = outs_reg[4];
  assign test_force_enable = outs_reg[5];
  assign port_functional = outs_reg[6];
  assign led_amber = led_code_amber;
  assign led_green = led_code_green;
  assign port_handover_to_companion = owner_reg; // RULE8
  assign hs_owns_port = !owner_reg; // RULE8
  assign port_power_on = power_eff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_reg);

  owner_forced_a: assert property (!configured_flag |=> port_handover_to_companion) // RULE6
    else $error("ownership not forced while configured flag low");
  owner_clear_a: assert property ($rose(configured_flag) |=> !port_handover_to_companion) // RULE5
    else $error("ownership not cleared on configured flag rise");
  owner_write_a: assert property (configured_flag && !cfg_rise && reg_wr // RULE7 RULE8
    |=> port_handover_to_companion == $past(reg_wdata[`PHC_BIT]))
    else $error("ownership write not taken");

  led_ignore_a: assert property (!indicator_capability |=> $stable(led_reg)) // RULE2
    else $error("indicator field changed without capability");
  led_green_a: assert property (reg_wr && indicator_capability // RULE3
    && reg_wdata[`PLS_MSB:`PLS_LSB] == 2'h2
    |=> led_reg == 2'h2 && (!indicator_capability || (led_green && !led_amber)))
    else $error("green not shown");
  led_amber_a: assert property (indicator_capability && led_reg == 2'h1 // RULE3
    |-> led_amber && !led_green)
    else $error("amber not shown");
  led_off_a: assert property (led_reg == 2'h0 |-> !led_amber && !led_green) // RULE3
    else $error("leds lit with indicator off");
  led_undef_a: assert property (led_reg == 2'h3 |-> !led_green && !led_amber) // RULE14
    else $error("undefined indicator code drives led");

  power_fixed_a: assert property (!power_switch_capability |-> port_power_on) // RULE9
    else $error("unswitched port not powered");
  power_image_a: assert property (!power_switch_capability |=> reg_rdata[`PPO_BIT]) // RULE9
    else $error("unswitched port power bit reads zero");
  oc_trip_a: assert property (power_switch_capability && port_power_on && overcurrent_in // RULE12
    |=> !power_reg)
    else $error("overcurrent did not remove power");
  power_write_a: assert property (reg_wr && power_switch_capability && !overcurrent_in // RULE10
    |=> power_reg == $past(reg_wdata[`PPO_BIT]))
    else $error("power write not taken");
  dead_port_a: assert property (!port_power_on |=> !port_functional && !test_active) // RULE11
    else $error("unpowered port reports status");
  live_port_a: assert property (port_power_on |=> port_functional) // RULE11
    else $error("powered port not functional");

  test_pkt_a: assert property (test_reg == 4'h4 && port_power_on // RULE1
    |=> test_packet && test_active)
    else $error("test packet mode not selected");
  test_fe_a: assert property (test_reg == 4'h5 && port_power_on // RULE1
    |=> test_force_enable && test_active && !test_packet)
    else $error("forced enable mode not selected");
  test_off_a: assert property (test_reg == 4'h0 // RULE13
    |=> !test_active && !test_packet && !test_force_enable)
    else $error("test mode active with test code zero");
  test_rsvd_a: assert property (test_reg > 4'h5 // RULE1 RULE14
    |=> !test_active && !test_packet && !test_force_enable)
    else $error("reserved test code selects a mode");

  handover_c: cover property (configured_flag && reg_wr && reg_wdata[`PHC_BIT] ##1
    port_handover_to_companion);
  cfg_rise_c: cover property ($rose(configured_flag) ##1 hs_owns_port);
  oc_c: cover property (oc_trip ##1 !port_power_on);
  force_en_c: cover property (test_force_enable);
  amber_c: cover property (led_amber);

endmodule // port_ctl

// file: verif/usb_dev_model.sv
// attached device model: shorts its supply on demand while powered
`timescale 1ns/1ps
module usb_dev_model (
  input wire logic powered,
  input wire logic short_cmd,
  output logic overcurrent
);
  assign overcurrent = powered & short_cmd;
endmodule // usb_dev_model

// file: verif/testbench.sv
// bench for the port control block
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, ind_cap = 1'b0, pwr_cap = 1'b1, cfg = 1'b0;
  logic reg_wr = 1'b0, short_cmd = 1'b0, oc;
  logic [31:0] wdata = 32'h0, rdata;
  logic amb, grn, ho, hs, pon, func, tact, tj, tk, tse0, tpkt, tfe;
  logic [7:0] e;
  int err_total = 0, compares = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  port_ctl i_port_ctl (.clk(clk), .rst_n(rst_n), .indicator_capability(ind_cap),
    .power_switch_capability(pwr_cap), .configured_flag(cfg), .overcurrent_in(oc),
    .reg_wr(reg_wr), .reg_wdata(wdata), .reg_rdata(rdata), .led_amber(amb), .led_green(grn),
    .port_handover_to_companion(ho), .hs_owns_port(hs), .port_power_on(pon),
    .port_functional(func), .test_active(tact), .test_j(tj), .test_k(tk),
    .test_se0_nak(tse0), .test_packet(tpkt), .test_force_enable(tfe));
  usb_dev_model i_usb_dev_model (.powered(pon), .short_cmd(short_cmd), .overcurrent(oc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one register write, then let read image and decodes settle
  task automatic wr(input logic [3:0] t, input logic [1:0] l, input logic o, input logic p);
    @(negedge clk);
    wdata = {12'h0, t, l, o, p, 12'h0};
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic final_report;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_owner;
    chk(rdata, 32'h2000);
    wr(4'h0, 2'h0, 1'b0, 1'b0);
    chk(ho, 1'b1);
    cfg = 1'b1;
    repeat (2) @(negedge clk);
    chk({ho, hs}, 2'b01);
    wr(4'h0, 2'h0, 1'b1, 1'b0);
    chk({ho, hs, rdata[13]}, 3'b101);
    $display("owner test done");
  endtask
  task automatic t_led;
    wr(4'h0, 2'h2, 1'b1, 1'b0);
    chk({rdata[15:14], amb, grn}, 4'h0);
    ind_cap = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, i[1:0], 1'b1, 1'b0);
      chk({rdata[15:14], amb, grn}, {i[1:0], i == 1, i == 2});
    end
    $display("led test done");
  endtask
  task automatic t_power;
    pwr_cap = 1'b0;
    @(negedge clk);
    chk(pon, 1'b1);
    pwr_cap = 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(c[3:0], 2'h0, 1'b0, 1'b1);
      e = {2'b11, c > 0 && c < 6, c == 1, c == 2, c == 3, c == 4, c == 5};
      chk({pon, func, tact, tj, tk, tse0, tpkt, tfe}, e);
    end
    wr(4'h4, 2'h0, 1'b0, 1'b0);
    chk({rdata[12], pon, func, tact, tpkt}, 5'h0);
    wr(4'h0, 2'h0, 1'b0, 1'b1);
    short_cmd = 1'b1;
    repeat (2) @(negedge clk);
    chk({rdata[12], pon, func}, 3'h0);
    short_cmd = 1'b0;
    $display("power test done");
  endtask
  // mid-run reset with the port handed to the high-speed side
  task automatic t_reset;
    rst_n = 1'b0;
    @(negedge clk);
    chk({ho, hs, pon, func, grn, amb}, 6'h20);
    cfg = 1'b0;
    repeat (15) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(rdata, 32'h2000);
    cfg = 1'b1;
    repeat (2) @(negedge clk);
    chk({ho, hs}, 2'b01);
    $display("reset test done");
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_owner;
    t_led;
    t_power;
    t_reset;
    final_report;
  end
endmodule // testbench
